// file: src/atm_pkg.sv
// constants and types shared by the audio timer design
package atm_pkg;

  // ==========================================================
  // register byte addresses on the apb bus
  localparam logic [7:0] ATM_OFS_CTRL0  = 8'h00;
  localparam logic [7:0] ATM_OFS_CTRL1  = 8'h04;
  localparam logic [7:0] ATM_OFS_CNT_LO = 8'h08;
  localparam logic [7:0] ATM_OFS_CNT_HI = 8'h0C;
  localparam logic [7:0] ATM_OFS_CMPA_L = 8'h10;
  localparam logic [7:0] ATM_OFS_CMPA_H = 8'h14;
  localparam logic [7:0] ATM_OFS_CMPB_L = 8'h18;
  localparam logic [7:0] ATM_OFS_CMPB_H = 8'h1C;
  localparam logic [7:0] ATM_OFS_PER    = 8'h20;

  // ==========================================================
  // control register 0 fields
  localparam int ATM_C0_HOLD   = 7;
  localparam int ATM_C0_CLK_HI = 6;
  localparam int ATM_C0_CLK_LO = 4;
  localparam int ATM_C0_RUN    = 3;
  localparam int ATM_C0_AUDIO  = 0;
  localparam logic [7:0] ATM_C0_MASK = 8'hF9;

  // ==========================================================
  // control register 1 fields
  localparam int ATM_C1_MODE_HI = 7;
  localparam int ATM_C1_MODE_LO = 6;
  localparam int ATM_C1_ACT_HI  = 5;
  localparam int ATM_C1_ACT_LO  = 4;
  localparam int ATM_C1_INIT    = 3;
  localparam int ATM_C1_INV     = 2;
  localparam int ATM_C1_SWAP    = 1;
  localparam int ATM_C1_CLRSEL  = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] ATM_CTRL_RST = 8'h00;
  localparam logic [9:0] ATM_CMP_RST  = 10'h000;
  localparam logic [7:0] ATM_PER_RST  = 8'h00;
  localparam logic [9:0] ATM_CNT_RST  = 10'h000;

  // ==========================================================
  // prescaler terminal counts
  localparam logic [5:0] ATM_DIV4_MASK  = 6'h03;
  localparam logic [5:0] ATM_DIV16_MASK = 6'h0F;
  localparam logic [5:0] ATM_DIV64_MASK = 6'h3F;

  // ==========================================================
  // operating modes, pin actions and clock sources
  typedef enum logic [1:0] {
    ATM_MODE_CMP   = 2'b00,
    ATM_MODE_UNDEF = 2'b01,
    ATM_MODE_PWM   = 2'b10,
    ATM_MODE_TMR   = 2'b11
  } atm_mode_type;

  typedef enum logic [1:0] {
    ATM_ACT_00 = 2'b00,
    ATM_ACT_01 = 2'b01,
    ATM_ACT_10 = 2'b10,
    ATM_ACT_11 = 2'b11
  } atm_act_type;

  typedef enum logic [2:0] {
    ATM_CLK_SYS4  = 3'b000,
    ATM_CLK_SYS   = 3'b001,
    ATM_CLK_H16   = 3'b010,
    ATM_CLK_H64   = 3'b011,
    ATM_CLK_SUB   = 3'b100,
    ATM_CLK_H     = 3'b101,
    ATM_CLK_EXT_R = 3'b110,
    ATM_CLK_EXT_F = 3'b111
  } atm_clk_type;

endpackage

// file: src/atm_tick_if.sv
// carrier between the timer core and its clock tick generator
`timescale 1ns/1ps
interface atm_tick_if;
  logic [2:0] clock_source_field;
  logic       external_clock_pin;
  logic       sub_clock_tick;
  logic       tick;

  modport gen  (input clock_source_field, input external_clock_pin, input sub_clock_tick, output tick);
  modport core (output clock_source_field, output external_clock_pin, output sub_clock_tick, input tick);
endinterface

// file: src/atm_tick_gen.sv
// counter clock tick selection, prescaler and external edge detection
`timescale 1ns/1ps
module atm_tick_gen
  import atm_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  atm_tick_if.gen    tif
);

  logic [5:0] pre_ff;
  logic       ext_s1_ff;
  logic       ext_s2_ff;
  logic       ext_s3_ff;
  logic       tick_ff;
  logic       nxt_tick;

  // ==========================================================
  // free running prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 6'h00;
    end else begin
      pre_ff <= pre_ff + 6'h01;
    end
  end

  // ==========================================================
  // external pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end else begin
      ext_s1_ff <= tif.external_clock_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // ==========================================================
  // source select
  always_comb begin
    unique case (atm_clk_type'(tif.clock_source_field))
      ATM_CLK_SYS4:  nxt_tick = (pre_ff & ATM_DIV4_MASK) == ATM_DIV4_MASK;
      ATM_CLK_SYS:   nxt_tick = 1'b1;
      ATM_CLK_H16:   nxt_tick = (pre_ff & ATM_DIV16_MASK) == ATM_DIV16_MASK;
      ATM_CLK_H64:   nxt_tick = pre_ff == ATM_DIV64_MASK;
      ATM_CLK_SUB:   nxt_tick = tif.sub_clock_tick;
      ATM_CLK_H:     nxt_tick = 1'b1;
      ATM_CLK_EXT_R: nxt_tick = ext_s2_ff & ~ext_s3_ff;
      ATM_CLK_EXT_F: nxt_tick = ~ext_s2_ff & ext_s3_ff;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  assign tif.tick = tick_ff;

endmodule // atm_tick_gen

// file: src/atm_audio_timer.sv
// audio timer: 10-bit counter, three comparators, compare, timer and pwm outputs
//
// How it works
// - ten-bit counter increments on each tick
// - period compare meets counter upper eight bits
// - compare a and b meet all bits
// - run rising edge clears counter; no writes
// - overflow or comparator match clears counter, event
// - hold bit freezes counter, resumes afterwards
// - three-bit field selects counter clock source
// - run low stops counting, keeps value
// - run rising edge loads initial pin level, except in timer mode
// - audio select picks audio pwm sub-mode
// - mode field: compare, undefined, pwm, timer
// - timer mode ignores pin action field
// - compare a match applies pin action
// - pwm pin action: inactive, active, waveform
// - requested level equal initial leaves pin
// - initial level bit sets starting pin level
// - complementary pin carries inverse of main
// - audio mode drives speaker pins instead
// - control 0 bits 2,1 read zero
// - invert bit inverts pin, not timer or undefined mode
// - in pwm initial level sets polarity
// - swap exchanges period/duty; audio clears swap
// - clear source selects comparator a or p, outside pwm mode
`timescale 1ns/1ps
module atm_audio_timer
  import atm_pkg::*;
#(
  parameter int CNT_W = 10,
  parameter int PER_W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         external_clock_pin,
  input  wire logic         sub_clock_tick,
  output logic              main_output_pin,
  output logic              inverted_output_pin,
  output logic              speaker_drive_a,
  output logic              speaker_drive_b,
  output logic              match_a_event,
  output logic              match_b_event,
  output logic              match_p_event
);

  // ==========================================================
  // declarations
  logic [7:0]       ctrl0_ff;
  logic [7:0]       ctrl1_ff;
  logic [CNT_W-1:0] cmpa_ff;
  logic [CNT_W-1:0] cmpb_ff;
  logic [PER_W-1:0] per_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic             run_d_ff;
  logic             pin_state_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic             main_ff;
  logic             inv_ff;
  logic             spk_a_ff;
  logic             spk_b_ff;
  logic             evt_a_ff;
  logic             evt_b_ff;
  logic             evt_p_ff;

  logic             acc;
  logic             wr;
  logic             mapped;
  logic [31:0]      nxt_rdata;
  logic [7:0]       nxt_ctrl1;
  logic [7:0]       wbyte;

  atm_mode_type     mode;
  atm_act_type      act;
  logic             run;
  logic             hold;
  logic             audio;
  logic             init_lvl;
  logic             invert;
  logic             swap;
  logic             clr_sel;
  logic             run_rise;
  logic             step;
  logic [CNT_W-1:0] cnt_inc;
  logic             p_hit;
  logic             a_raw;
  logic             a_hit;
  logic             b_hit;
  logic             clr;
  logic [CNT_W:0]   per_full;
  logic [CNT_W:0]   duty_val;
  logic             wave;
  logic             nxt_pin_state;
  logic             nxt_main;

  atm_tick_if tif ();

  // ==========================================================
  // clock tick generator
  assign tif.clock_source_field = ctrl0_ff[ATM_C0_CLK_HI:ATM_C0_CLK_LO];
  assign tif.external_clock_pin = external_clock_pin;
  assign tif.sub_clock_tick     = sub_clock_tick;

  atm_tick_gen u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif)
  );

  // ==========================================================
  // field decode
  assign mode     = atm_mode_type'(ctrl1_ff[ATM_C1_MODE_HI:ATM_C1_MODE_LO]);
  assign act      = atm_act_type'(ctrl1_ff[ATM_C1_ACT_HI:ATM_C1_ACT_LO]);
  assign run      = ctrl0_ff[ATM_C0_RUN];
  assign hold     = ctrl0_ff[ATM_C0_HOLD];
  assign audio    = ctrl0_ff[ATM_C0_AUDIO] && (mode == ATM_MODE_PWM);
  assign init_lvl = ctrl1_ff[ATM_C1_INIT];
  assign invert   = ctrl1_ff[ATM_C1_INV];
  assign swap     = ctrl1_ff[ATM_C1_SWAP];
  assign clr_sel  = ctrl1_ff[ATM_C1_CLRSEL];

  // ==========================================================
  // apb slave, one wait state
  assign acc    = psel && penable && pready_ff;
  assign wr     = acc && pwrite;
  assign wbyte  = pwdata[7:0];
  assign mapped = (paddr == ATM_OFS_CTRL0) || (paddr == ATM_OFS_CTRL1) ||
                  (paddr == ATM_OFS_CNT_LO) || (paddr == ATM_OFS_CNT_HI) ||
                  (paddr == ATM_OFS_CMPA_L) || (paddr == ATM_OFS_CMPA_H) ||
                  (paddr == ATM_OFS_CMPB_L) || (paddr == ATM_OFS_CMPB_H) ||
                  (paddr == ATM_OFS_PER);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= psel && penable && !pready_ff && !mapped;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (paddr)
      ATM_OFS_CTRL0:  nxt_rdata[7:0] = ctrl0_ff & ATM_C0_MASK;
      ATM_OFS_CTRL1:  nxt_rdata[7:0] = ctrl1_ff;
      ATM_OFS_CNT_LO: nxt_rdata[7:0] = cnt_ff[7:0];
      ATM_OFS_CNT_HI: nxt_rdata[1:0] = cnt_ff[CNT_W-1:8];
      ATM_OFS_CMPA_L: nxt_rdata[7:0] = cmpa_ff[7:0];
      ATM_OFS_CMPA_H: nxt_rdata[1:0] = cmpa_ff[CNT_W-1:8];
      ATM_OFS_CMPB_L: nxt_rdata[7:0] = cmpb_ff[7:0];
      ATM_OFS_CMPB_H: nxt_rdata[1:0] = cmpb_ff[CNT_W-1:8];
      ATM_OFS_PER:    nxt_rdata[7:0] = per_ff;
      default:        nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && penable && !pready_ff && !pwrite) begin
      prdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_ff <= ATM_CTRL_RST;
    end else if (wr && paddr == ATM_OFS_CTRL0) begin
      ctrl0_ff <= wbyte & ATM_C0_MASK;
    end
  end

  always_comb begin
    nxt_ctrl1 = ctrl1_ff;
    if (wr && paddr == ATM_OFS_CTRL1) begin
      nxt_ctrl1 = wbyte;
    end
    if (audio) begin
      nxt_ctrl1[ATM_C1_SWAP] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_ff <= ATM_CTRL_RST;
    end else begin
      ctrl1_ff <= nxt_ctrl1;
    end
  end

  // ==========================================================
  // compare value registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_ff <= ATM_CMP_RST;
      cmpb_ff <= ATM_CMP_RST;
      per_ff  <= ATM_PER_RST;
    end else if (wr) begin
      unique case (paddr)
        ATM_OFS_CMPA_L: cmpa_ff[7:0]       <= wbyte;
        ATM_OFS_CMPA_H: cmpa_ff[CNT_W-1:8] <= wbyte[1:0];
        ATM_OFS_CMPB_L: cmpb_ff[7:0]       <= wbyte;
        ATM_OFS_CMPB_H: cmpb_ff[CNT_W-1:8] <= wbyte[1:0];
        ATM_OFS_PER:    per_ff             <= wbyte;
        default:        per_ff             <= per_ff;
      endcase
    end
  end

  // ==========================================================
  // comparators, matching the next count value
  assign run_rise = run && !run_d_ff;
  assign step     = tif.tick && run && !hold;
  assign cnt_inc  = cnt_ff + 1'b1;
  assign p_hit    = cnt_inc[CNT_W-1:2] == per_ff && cnt_inc[1:0] == 2'b00;
  assign a_raw    = cnt_inc == cmpa_ff;
  assign a_hit    = a_raw && (cmpa_ff != ATM_CMP_RST);
  assign b_hit    = (cnt_inc == cmpb_ff) && (cmpb_ff != ATM_CMP_RST);

  always_comb begin
    if (mode == ATM_MODE_PWM) begin
      clr = (swap && !audio) ? a_raw : p_hit;
    end else begin
      clr = clr_sel ? a_raw : p_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_d_ff <= 1'b0;
    end else begin
      run_d_ff <= run;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= ATM_CNT_RST;
    end else if (run_rise) begin
      cnt_ff <= ATM_CNT_RST;
    end else if (step) begin
      cnt_ff <= clr ? ATM_CNT_RST : cnt_inc;
    end
  end

  // ==========================================================
  // match events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_a_ff <= 1'b0;
      evt_b_ff <= 1'b0;
      evt_p_ff <= 1'b0;
    end else begin
      evt_a_ff <= step && a_hit;
      evt_b_ff <= step && b_hit;
      evt_p_ff <= step && p_hit && !(clr_sel && mode != ATM_MODE_PWM);
    end
  end

  // ==========================================================
  // compare match pin state
  always_comb begin
    nxt_pin_state = pin_state_ff;
    if (run_rise && mode != ATM_MODE_TMR) begin
      nxt_pin_state = init_lvl;
    end else if (step && a_hit && mode == ATM_MODE_CMP) begin
      unique case (act)
        ATM_ACT_00: nxt_pin_state = pin_state_ff;
        ATM_ACT_01: nxt_pin_state = init_lvl ? 1'b0 : pin_state_ff;
        ATM_ACT_10: nxt_pin_state = init_lvl ? pin_state_ff : 1'b1;
        ATM_ACT_11: nxt_pin_state = !pin_state_ff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_state_ff <= 1'b0;
    end else begin
      pin_state_ff <= nxt_pin_state;
    end
  end

  // ==========================================================
  // pwm waveform
  assign per_full = (per_ff == ATM_PER_RST) ? {1'b1, {CNT_W{1'b0}}} : {1'b0, per_ff, 2'b00};
  assign duty_val = (swap && !audio) ? per_full : {1'b0, cmpa_ff};
  assign wave     = {1'b0, cnt_ff} < duty_val;

  always_comb begin
    nxt_main = pin_state_ff;
    unique case (mode)
      ATM_MODE_CMP: nxt_main = pin_state_ff ^ invert;
      ATM_MODE_PWM: begin
        unique case (act)
          ATM_ACT_00: nxt_main = !init_lvl ^ invert;
          ATM_ACT_01: nxt_main = init_lvl ^ invert;
          ATM_ACT_10: nxt_main = (wave ? init_lvl : !init_lvl) ^ invert;
          ATM_ACT_11: nxt_main = !init_lvl ^ invert;
        endcase
      end
      ATM_MODE_UNDEF: nxt_main = pin_state_ff;
      ATM_MODE_TMR: nxt_main = main_ff;
    endcase
  end

  // ==========================================================
  // pin routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ff  <= 1'b0;
      inv_ff   <= 1'b1;
      spk_a_ff <= 1'b0;
      spk_b_ff <= 1'b0;
    end else if (audio) begin
      main_ff  <= main_ff;
      inv_ff   <= inv_ff;
      spk_a_ff <= (wave ? init_lvl : !init_lvl) ^ invert;
      spk_b_ff <= (({1'b0, cnt_ff} < {1'b0, cmpb_ff}) ? init_lvl : !init_lvl) ^ invert;
    end else begin
      main_ff  <= nxt_main;
      inv_ff   <= !nxt_main;
      spk_a_ff <= 1'b0;
      spk_b_ff <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign main_output_pin     = main_ff;
  assign inverted_output_pin = inv_ff;
  assign speaker_drive_a     = spk_a_ff;
  assign speaker_drive_b     = spk_b_ff;
  assign match_a_event       = evt_a_ff;
  assign match_b_event       = evt_b_ff;
  assign match_p_event       = evt_p_ff;

endmodule // atm_audio_timer

// file: bench/atm_audio_timer_checker.sv
// port-level assertions for the audio timer
`timescale 1ns/1ps
module atm_audio_timer_checker
  import atm_pkg::*;
#(parameter int CNT_W = 10, parameter int PER_W = 8) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        external_clock_pin,
  input wire logic        sub_clock_tick,
  input wire logic        main_output_pin,
  input wire logic        inverted_output_pin,
  input wire logic        speaker_drive_a,
  input wire logic        speaker_drive_b,
  input wire logic        match_a_event,
  input wire logic        match_b_event,
  input wire logic        match_p_event
);
  logic [7:0] c0_ff;
  logic [7:0] c1_ff;
  logic       wr;
  logic       rd;
  logic       aud;
  assign wr  = psel && penable && pready && pwrite;
  assign rd  = psel && penable && pready && !pwrite;
  assign aud = (c1_ff[7:6] == ATM_MODE_PWM) && c0_ff[ATM_C0_AUDIO];
  // ==========================================================
  // control shadows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c0_ff <= ATM_CTRL_RST;
    else if (wr && paddr == ATM_OFS_CTRL0) c0_ff <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c1_ff <= ATM_CTRL_RST;
    else if (wr && paddr == ATM_OFS_CTRL1) c1_ff <= pwdata[7:0];
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence run_start_s;
    wr && paddr == ATM_OFS_CTRL0 && pwdata[ATM_C0_RUN] && !c0_ff[ATM_C0_RUN] && c1_ff[7:6] == ATM_MODE_CMP;
  endsequence
  sequence normal_s;
    !aud [*3];
  endsequence
  pready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  pready_wait_a: assert property ($rose(penable) |-> ##[0:2] pready) else $error("no ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (psel && penable && pready |-> pslverr == (paddr > ATM_OFS_PER || paddr[1:0] != 2'b00))
    else $error("error flag wrong");
  read_upper_a: assert property (rd |-> prdata[31:8] == '0) else $error("upper read bits set");
  ctrl_gap_a: assert property (rd && paddr == ATM_OFS_CTRL0 |-> prdata[2:1] == 2'b00) else $error("gap bits set");
  high_byte_a: assert property (rd && (paddr == ATM_OFS_CNT_HI || paddr == ATM_OFS_CMPA_H || paddr == ATM_OFS_CMPB_H)
    |-> prdata[7:2] == 6'h00) else $error("high byte upper bits set");
  pin_pair_a: assert property (normal_s |-> inverted_output_pin == !main_output_pin) else $error("pins not paired");
  speaker_idle_a: assert property (normal_s |-> !speaker_drive_a && !speaker_drive_b) else $error("speaker active");
  init_level_a: assert property (run_start_s |-> ##3 main_output_pin == (c1_ff[ATM_C1_INIT] ^ c1_ff[ATM_C1_INV]))
    else $error("initial level wrong");
  stop_quiet_a: assert property (!c0_ff[ATM_C0_RUN] [*3] |-> !(match_a_event || match_b_event || match_p_event))
    else $error("event while stopped");
endmodule // atm_audio_timer_checker

bind atm_audio_timer atm_audio_timer_checker #(.CNT_W(CNT_W), .PER_W(PER_W)) chk_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_clock_pin, .sub_clock_tick,
  .main_output_pin, .inverted_output_pin, .speaker_drive_a, .speaker_drive_b, .match_a_event, .match_b_event,
  .match_p_event);

// file: bench/atm_speaker_model.sv
// far side: external count clock source and speaker driver observer
`timescale 1ns/1ps
module atm_speaker_model (
  input  wire logic pclk,
  input  wire logic clr,
  input  wire logic ext_run,
  input  wire logic main_pin,
  input  wire logic spk_a,
  input  wire logic spk_b,
  input  wire logic ev_a,
  input  wire logic ev_p,
  output logic      ext_pin,
  output int        hi_m,
  output int        hi_a,
  output int        hi_b,
  output int        n_a,
  output int        n_p
);
  int div_n = 0;
  initial ext_pin = 1'b0;
  // ==========================================================
  // pin clock, still while disabled
  always @(posedge pclk) begin
    if (!ext_run) div_n <= 0;
    else if (div_n == 9) div_n <= 0;
    else div_n <= div_n + 1;
    if (ext_run && div_n == 9) ext_pin <= ~ext_pin;
  end
  // ==========================================================
  // high-time and event counters
  always @(posedge pclk) begin
    if (clr) begin
      {hi_m, hi_a, hi_b, n_a, n_p} <= '0;
    end else begin
      hi_m <= hi_m + int'(main_pin);
      hi_a <= hi_a + int'(spk_a);
      hi_b <= hi_b + int'(spk_b);
      n_a <= n_a + int'(ev_a);
      n_p <= n_p + int'(ev_p);
    end
  end
endmodule // atm_speaker_model

// file: bench/atm_audio_timer_bench.sv
// self-checking bench for the audio timer
`timescale 1ns/1ps
module atm_audio_timer_bench
  import atm_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, sub_tick, clr, ext_run, err;
  logic [7:0]  paddr, q;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, ext_pin, main_pin, inv_pin, spk_a, spk_b, ev_a, ev_b, ev_p;
  int          hi_m, hi_a, hi_b, n_a, n_p, n_b, checks, bad_count, sub_n;
  atm_audio_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_clock_pin(ext_pin), .sub_clock_tick(sub_tick), .main_output_pin(main_pin),
    .inverted_output_pin(inv_pin), .speaker_drive_a(spk_a), .speaker_drive_b(spk_b), .match_a_event(ev_a),
    .match_b_event(ev_b), .match_p_event(ev_p));
  atm_speaker_model far_i (.pclk, .clr, .ext_run, .main_pin, .spk_a, .spk_b, .ev_a, .ev_p, .ext_pin, .hi_m,
    .hi_a, .hi_b, .n_a, .n_p);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    sub_n <= (sub_n + 1) % 8;
    sub_tick <= (sub_n == 7);
  end
  always @(posedge pclk) n_b <= clr ? 0 : n_b + int'(ev_b);
  // ==========================================================
  // helpers
  task automatic final_report();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic fail(input string m);
    bad_count++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string m);
    checks++;
    if ($isunknown(got) || got < lo || got > hi) fail($sformatf("%s got %0h", m, got));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      fail("bus hang");
      final_report();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(q, e, e, "read");
  endtask
  task automatic rdcnt(output logic [9:0] c);
    apb(1'b0, ATM_OFS_CNT_LO, 8'h00);
    c[7:0] = q;
    apb(1'b0, ATM_OFS_CNT_HI, 8'h00);
    c[9:8] = q[1:0];
  endtask
  task automatic window();
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (64) @(posedge pclk);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    for (int i = 0; i < 9; i++) rdc(8'(4 * i), 8'h00);
    apb(1'b0, 8'h24, 8'h00);
    chk({q, 7'h00, err}, 1, 1, "unmapped");
    apb(1'b1, ATM_OFS_CTRL0, 8'h86);
    rdc(ATM_OFS_CTRL0, 8'h80);
    apb(1'b1, ATM_OFS_CTRL0, 8'h00);
    apb(1'b1, ATM_OFS_CMPA_L, 8'hFF);
    apb(1'b1, ATM_OFS_CMPA_H, 8'hFF);
    rdc(ATM_OFS_CMPA_H, 8'h03);
    rdc(ATM_OFS_CMPA_L, 8'hFF);
    apb(1'b1, ATM_OFS_CNT_LO, 8'h55);
    rdc(ATM_OFS_CNT_LO, 8'h00);
    $display("regs test done");
  endtask
  task automatic t_src();
    int         dv[8] = '{4, 1, 16, 64, 8, 1, 20, 20};
    logic [9:0] c1, c2;
    ext_run <= 1'b1;
    apb(1'b1, ATM_OFS_CTRL1, 8'hC0);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, ATM_OFS_CTRL0, {1'b0, 3'(s), 4'h8});
      repeat (200) @(posedge pclk);
      apb(1'b1, ATM_OFS_CTRL0, {1'b1, 3'(s), 4'h8});
      rdcnt(c1);
      chk(c1, 198 / dv[s] - 1, 208 / dv[s] + 1, "count rate");
      apb(1'b1, ATM_OFS_CTRL0, {1'b0, 3'(s), 4'h0});
      rdcnt(c2);
      chk(c2, c1, c1, "residual");
    end
    apb(1'b1, ATM_OFS_CTRL0, 8'h98);
    rdcnt(c1);
    chk(c1, 0, 0, "restart clear");
    apb(1'b1, ATM_OFS_CTRL0, 8'h00);
    ext_run <= 1'b0;
    $display("source test done");
  endtask
  task automatic t_clr();
    apb(1'b1, ATM_OFS_CTRL1, 8'h00);
    apb(1'b1, ATM_OFS_PER, 8'h01);
    apb(1'b1, ATM_OFS_CMPA_L, 8'h05);
    apb(1'b1, ATM_OFS_CMPA_H, 8'h00);
    apb(1'b1, ATM_OFS_CTRL0, 8'h18);
    window();
    chk(n_p, 16, 16, "p rate");
    apb(1'b0, ATM_OFS_CNT_LO, 8'h00);
    chk(q, 0, 4, "p bound");
    apb(1'b1, ATM_OFS_CTRL0, 8'h00);
    apb(1'b1, ATM_OFS_CTRL1, 8'h01);
    apb(1'b1, ATM_OFS_CTRL0, 8'h18);
    window();
    chk(n_p, 0, 0, "p events");
    chk(n_a, 10, 13, "a rate");
    apb(1'b1, ATM_OFS_CTRL0, 8'h00);
    $display("clear test done");
  endtask
  task automatic t_cmp();
    logic [3:0] cc[7] = '{4'h4, 4'h8, 4'h6, 4'hA, 4'hC, 4'h9, 4'h2};
    logic       ce[7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    int         n;
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ATM_OFS_CTRL1, {2'b00, cc[i], 2'b01});
      apb(1'b1, ATM_OFS_CTRL0, 8'h18);
      @(posedge pclk);
      #1;
      chk(main_pin, cc[i][1] ^ cc[i][0], cc[i][1] ^ cc[i][0], "initial");
      n = 0;
      while (ev_a !== 1'b1 && n < 40) begin
        @(posedge pclk);
        #1;
        n++;
      end
      if (n >= 40) begin
        fail("no match");
        final_report();
      end
      @(posedge pclk);
      #1;
      chk(main_pin, ce[i], ce[i], "after match");
      chk(inv_pin, !main_pin, !main_pin, "complement");
      apb(1'b1, ATM_OFS_CTRL0, 8'h00);
    end
    $display("compare test done");
  endtask
  task automatic t_pwm();
    logic [7:0] cv[7] = '{8'hA8, 8'hA0, 8'h88, 8'h98, 8'hAC, 8'hAA, 8'hAA};
    int         em[7] = '{16, 48, 0, 64, 48, 64, 0};
    apb(1'b1, ATM_OFS_PER, 8'h04);
    apb(1'b1, ATM_OFS_CMPA_L, 8'h04);
    apb(1'b1, ATM_OFS_CMPB_L, 8'h0C);
    apb(1'b1, ATM_OFS_CMPB_H, 8'h00);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ATM_OFS_CTRL1, cv[i]);
      apb(1'b1, ATM_OFS_CTRL0, (i == 6) ? 8'h19 : 8'h18);
      repeat (4) @(posedge pclk);
      window();
      if (i < 6) chk(hi_m, em[i], em[i], "duty");
      if (i == 0) chk(n_b, 4, 4, "b match");
      chk(hi_a, (i == 6) ? 16 : 0, (i == 6) ? 16 : 0, "speaker a");
      chk(hi_b, (i == 6) ? 48 : 0, (i == 6) ? 48 : 0, "speaker b");
      apb(1'b1, ATM_OFS_CTRL0, 8'h00);
    end
    rdc(ATM_OFS_CTRL1, 8'hA8);
    $display("pwm test done");
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, clr, ext_run} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {checks, bad_count} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_src();
    t_clr();
    t_cmp();
    t_pwm();
    final_report();
  end
endmodule // atm_audio_timer_bench
